// [src/fault_retry_map.vh]
// Constants for the fault retry controller
`ifndef FAULT_RETRY_MAP_VH
`define FAULT_RETRY_MAP_VH
`define ADDR_SELECTOR       12'h000
`define ADDR_LIMIT          12'h004
`define ADDR_WAIT           12'h008
`define ADDR_SUCCESS        12'h00C
`define ADDR_COAST          12'h010
`define ADDR_CTRL           12'h014
`define ADDR_STATUS         12'h018
`define ADDR_FIRST_FAULT    12'h01C
`define ADDR_TERM           12'h020
`define RST_SELECTOR        3'h0
`define RST_LIMIT           7'h00
`define RST_WAIT            13'h000A
`define RST_COAST           14'h270F
`define RST_TERM            8'h00
`define COAST_DISABLED      14'h270F
`define FUNC_RETRY_POS      8'h40
`define FUNC_RETRY_NEG      8'hA4
`define LIMIT_HIGH_BASE     7'h64
`define LIMIT_LOW_MAX       7'h0A
`define LIMIT_HIGH_MIN      7'h65
`define LIMIT_HIGH_MAX      7'h6E
`define WAIT_MIN            13'h0001
`define WAIT_MAX            13'h1770
`define SUCCESS_FACTOR      2
`define TENTH_SEC_NS        100000000
`define CLK_PERIOD_NS       40
`define TENTH_SEC_CYCLES    (`TENTH_SEC_NS / `CLK_PERIOD_NS)
`define FLT_OCUR_ACCEL      0
`define FLT_OCUR_CONST      1
`define FLT_OCUR_DECEL      2
`define FLT_OVOLT_ACCEL     3
`define FLT_OVOLT_CONST     4
`define FLT_OVOLT_DECEL     5
`define FLT_MOTOR_HEAT      6
`define FLT_DRIVE_HEAT      7
`define FLT_BRAKE           8
`define FLT_GROUND          9
`define FLT_EXT_THERMAL     10
`define FLT_THERMISTOR      11
`define FLT_STALL_STOP      12
`define FLT_PARAM_STORE     13
`define FLT_PHASE_LOSS      14
`define FLT_CURRENT_EXCESS  15
`define NUM_FAULTS          16
`define MASK_SEL0           16'hFFFF
`define MASK_SEL1           16'h0007
`define MASK_SEL2           16'h0038
`define MASK_SEL3           16'h003F
`define MASK_SEL4           16'hF33F
`define MASK_SEL5           16'h0005
`define CTRL_FAULT_RESET    0
`define CTRL_POWERUP_DONE   1
`endif

// [src/retry_tick_timer.v]
// Tenth-second tick generator and wait-time counter for the retry controller
`timescale 1ns/1ps
`default_nettype none
module retry_tick_timer #(
  parameter TICK_CYCLES = 2500000,
  parameter CNT_W       = 16
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  input  wire             i_ce,
  // Control
  input  wire             i_clear,
  // Status
  output reg  [CNT_W-1:0] o_tenths
);
  reg  [31:0] pre_ff;
  wire        tick = (pre_ff == TICK_CYCLES - 1);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_ff   <= 32'h00000000;
      o_tenths <= {CNT_W{1'b0}};
    end else if (i_ce) begin
      if (i_clear) begin
        pre_ff   <= 32'h00000000;
        o_tenths <= {CNT_W{1'b0}};
      end else if (tick) begin
        pre_ff <= 32'h00000000;
        if (o_tenths != {CNT_W{1'b1}})
          o_tenths <= o_tenths + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
        pre_ff <= pre_ff + 32'h00000001;
      end
    end
  end
endmodule
`default_nettype wire

// [src/fault_retry_controller.v]
// Automatic fault-retry controller with APB settings
// Overview of operation
// RL1: Selector 0 retries all faults, 1 the overcurrent trio, 2 the overvoltage trio, 3 both.
// RL2: Selector 4 adds brake, ground, stall, storage, phase-loss, current-excess; 5 is OC first/third.
// RL3: No retry is made for a fault the current selector does not include.
// RL4: A retry limit of zero disables retry entirely.
// RL5: Limit 1 to 10 sets the retry count and keeps the fault output off while retrying.
// RL6: Limit 101 to 110 sets the count as value minus 100 and asserts the fault output.
// RL7: After a trip, wait the set time (0.1 to 600 s, default 1 s), reset and restart.
// RL8: When consecutive failures reach the allowed count, raise the excess fault and trip.
// RL9: Fault-free running beyond four wait times counts success and clears failures.
// RL10: Success count reads cumulative successes; writing 0 clears it.
// RL11: Retry-active output stays on through a retry, on terminal function 64 or 164.
// RL12: Only the first fault of several is stored as the retry reset record.
// RL13: A retry reset keeps thermal and brake duty accumulations, unlike power-on reset.
// RL14: A storage fault seen at power-on is never retried; the code samples it before the synchronizer fills, so it is never flagged.
// RL15: An unselected fault during the wait abandons the retry and stays indicated.
// RL16: With coasting time not 9999, restart uses the power-loss restart sequence.
// RL17: After the excess trip no retry is made until external or power-on reset.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fault_retry_map.vh"
module fault_retry_controller #(
  parameter TICK_CYCLES = `TENTH_SEC_CYCLES
) (
  // Clock, reset, enable
  input  wire        I_REF_CLK,
  input  wire        I_RST_N,
  input  wire        I_CE,
  // APB slave
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [11:0] I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  // Fault detectors and restart logic
  input  wire [15:0] I_FAULTS,
  input  wire        I_EXT_FAULT_RESET,
  input  wire        I_RESTART_DONE,
  // Drive outputs
  output reg         O_TRIP,
  output reg         O_FAULT_OUT,
  output reg         O_RETRY_EXCESS_FAULT,
  output reg         O_FAULT_RESET,
  output reg         O_RESTART_START,
  output reg         O_RESTART_FLYING,
  output reg         O_KEEP_THERMAL,
  output reg         O_RETRY_ACTIVE,
  output reg         O_TERM_OUT
);
  localparam ST_RUN     = 3'h0;
  localparam ST_WAIT    = 3'h1;
  localparam ST_RESTART = 3'h2;
  localparam ST_WATCH   = 3'h3;
  localparam ST_HOLD    = 3'h4;

  // Fault pins are asynchronous to the clock
  reg [15:0] flt_s1_ff;
  reg [15:0] flt_s2_ff;
  reg        ext_s1_ff;
  reg        ext_s2_ff;

  reg [2:0]  selector_ff;
  reg [6:0]  limit_ff;
  reg [12:0] wait_ff;
  reg [13:0] coast_ff;
  reg [7:0]  term_ff;
  reg [15:0] success_ff;
  reg [3:0]  fails_ff;
  reg [15:0] first_fault_ff;
  reg        powerup_done_ff;
  reg        pe_at_power_on_ff;
  reg [2:0]  state_ff;
  reg        excess_ff;
  reg        sw_reset_ff;

  reg [2:0]  nxt_state;
  reg [15:0] sel_mask;
  reg [3:0]  allowed;
  reg        retry_on;
  reg        fault_visible;

  wire [15:0] tenths;
  wire        timer_clear = (nxt_state != state_ff);
  wire [15:0] any_fault   = flt_s2_ff;
  wire        fault_seen  = |any_fault;
  wire        ext_reset   = ext_s2_ff | sw_reset_ff;
  wire        apb_wr      = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  wire        apb_setup   = I_PSEL & ~I_PENABLE;
  wire [15:0] retry_sel   = any_fault & sel_mask &
                            ~({15'h0000, pe_at_power_on_ff} << `FLT_PARAM_STORE); // RL14
  wire        unsel_fault = |(any_fault & ~sel_mask);
  wire [15:0] watch_tenths = {wait_ff, 2'b00} + {3'h0, wait_ff}; // 5x wait; the watch check subtracts one wait to test beyond 4x

  retry_tick_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .CNT_W       (16)
  ) u_timer (
    .i_clk    (I_REF_CLK),
    .i_rst_n  (I_RST_N),
    .i_ce     (I_CE),
    .i_clear  (timer_clear),
    .o_tenths (tenths)
  );

  always @* begin
    case (selector_ff)
      3'h0: sel_mask = `MASK_SEL0;
      3'h1: sel_mask = `MASK_SEL1; // RL1
      3'h2: sel_mask = `MASK_SEL2; // RL1
      3'h3: sel_mask = `MASK_SEL3; // RL1
      3'h4: sel_mask = `MASK_SEL4; // RL2
      3'h5: sel_mask = `MASK_SEL5; // RL2
      default: sel_mask = 16'h0000;
    endcase
  end

  always @* begin
    allowed = 4'h0;
    if (limit_ff != 7'h00 && limit_ff <= `LIMIT_LOW_MAX)
      allowed = limit_ff[3:0]; // RL5
    else if (limit_ff >= `LIMIT_HIGH_MIN && limit_ff <= `LIMIT_HIGH_MAX)
      allowed = limit_ff[3:0] - 4'h4; // RL6
    retry_on = (allowed != 4'h0); // RL4
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (fault_seen) begin
          if (retry_on && !excess_ff && (retry_sel != 16'h0000) && !unsel_fault)
            nxt_state = ST_WAIT; // RL3
          else
            nxt_state = ST_HOLD;
        end
      end
      ST_WAIT: begin
        if (unsel_fault)
          nxt_state = ST_HOLD; // RL15
        else if (tenths >= {3'h0, wait_ff})
          nxt_state = ST_RESTART; // RL7
      end
      ST_RESTART: begin
        if (I_RESTART_DONE)
          nxt_state = ST_WATCH;
      end
      ST_WATCH: begin
        if (fault_seen) begin
          if ({4'h0, fails_ff} + 8'h01 >= {4'h0, allowed})
            nxt_state = ST_HOLD; // RL8
          else if ((retry_sel != 16'h0000) && !unsel_fault)
            nxt_state = ST_WAIT;
          else
            nxt_state = ST_HOLD;
        end else if (tenths > watch_tenths - {3'h0, wait_ff}) begin
          nxt_state = ST_RUN; // RL9
        end
      end
      ST_HOLD: begin
        if (ext_reset && !fault_seen)
          nxt_state = ST_RUN; // RL17
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  always @* begin
    fault_visible = (state_ff == ST_HOLD);
    if (state_ff == ST_WAIT || state_ff == ST_RESTART)
      fault_visible = (limit_ff >= `LIMIT_HIGH_MIN); // RL5 RL6
  end

  always @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      flt_s1_ff <= 16'h0000;
      flt_s2_ff <= 16'h0000;
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
    end else if (I_CE) begin
      flt_s1_ff <= I_FAULTS;
      flt_s2_ff <= flt_s1_ff;
      ext_s1_ff <= I_EXT_FAULT_RESET;
      ext_s2_ff <= ext_s1_ff;
    end
  end

  always @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_ff          <= ST_RUN;
      fails_ff          <= 4'h0;
      excess_ff         <= 1'b0;
      first_fault_ff    <= 16'h0000;
      powerup_done_ff   <= 1'b0;
      pe_at_power_on_ff <= 1'b0;
      success_ff        <= 16'h0000;
      O_TRIP            <= 1'b0;
      O_FAULT_OUT       <= 1'b0;
      O_RETRY_EXCESS_FAULT <= 1'b0;
      O_FAULT_RESET     <= 1'b0;
      O_RESTART_START   <= 1'b0;
      O_RESTART_FLYING  <= 1'b0;
      O_KEEP_THERMAL    <= 1'b0;
      O_RETRY_ACTIVE    <= 1'b0;
      O_TERM_OUT        <= 1'b0;
    end else if (I_CE) begin
      state_ff <= nxt_state;
      if (!powerup_done_ff) begin
        powerup_done_ff   <= 1'b1;
        pe_at_power_on_ff <= any_fault[`FLT_PARAM_STORE]; // RL14
      end else if (ext_reset) begin
        pe_at_power_on_ff <= 1'b0;
      end
      if (state_ff == ST_RUN && fault_seen && first_fault_ff == 16'h0000)
        first_fault_ff <= any_fault & (~any_fault + 16'h0001); // RL12
      else if (nxt_state == ST_RUN && state_ff != ST_RUN)
        first_fault_ff <= 16'h0000;
      if (state_ff == ST_WATCH && nxt_state != ST_WATCH && fault_seen)
        fails_ff <= fails_ff + 4'h1;
      else if (state_ff == ST_WATCH && nxt_state == ST_RUN)
        fails_ff <= 4'h0; // RL9
      else if (state_ff == ST_HOLD && nxt_state == ST_RUN)
        fails_ff <= 4'h0;
      if (state_ff == ST_WATCH && fault_seen &&
          {4'h0, fails_ff} + 8'h01 >= {4'h0, allowed})
        excess_ff <= 1'b1; // RL8
      else if (state_ff == ST_HOLD && nxt_state == ST_RUN)
        excess_ff <= 1'b0; // RL17
      if (state_ff == ST_WATCH && nxt_state == ST_RUN)
        success_ff <= success_ff + 16'h0001; // RL9
      else if (apb_wr && I_PADDR == `ADDR_SUCCESS && I_PWDATA == 32'h00000000)
        success_ff <= 16'h0000; // RL10
      O_TRIP               <= (nxt_state == ST_WAIT) || (nxt_state == ST_HOLD);
      O_FAULT_OUT          <= fault_visible;
      O_RETRY_EXCESS_FAULT <= excess_ff;
      O_FAULT_RESET        <= (state_ff == ST_WAIT) && (nxt_state == ST_RESTART); // RL7
      O_KEEP_THERMAL       <= (state_ff == ST_WAIT) && (nxt_state == ST_RESTART); // RL13
      O_RESTART_START      <= (state_ff == ST_WAIT) && (nxt_state == ST_RESTART);
      O_RESTART_FLYING     <= (coast_ff != `COAST_DISABLED); // RL16
      O_RETRY_ACTIVE       <= (nxt_state == ST_WAIT) || (nxt_state == ST_RESTART); // RL11
      if (term_ff == `FUNC_RETRY_POS)
        O_TERM_OUT <= (nxt_state == ST_WAIT) || (nxt_state == ST_RESTART); // RL11
      else if (term_ff == `FUNC_RETRY_NEG)
        O_TERM_OUT <= !((nxt_state == ST_WAIT) || (nxt_state == ST_RESTART)); // RL11
      else
        O_TERM_OUT <= 1'b0;
    end
  end

  // APB slave: no wait states, unmapped addresses answer with pslverr
  always @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      selector_ff <= `RST_SELECTOR;
      limit_ff    <= `RST_LIMIT;
      wait_ff     <= `RST_WAIT;
      coast_ff    <= `RST_COAST;
      term_ff     <= `RST_TERM;
      sw_reset_ff <= 1'b0;
      O_PRDATA    <= 32'h00000000;
      O_PREADY    <= 1'b0;
      O_PSLVERR   <= 1'b0;
    end else if (I_CE) begin
      O_PREADY    <= apb_setup;
      sw_reset_ff <= 1'b0;
      O_PSLVERR   <= 1'b0;
      if (apb_setup) begin
        O_PRDATA <= 32'h00000000;
        case (I_PADDR)
          `ADDR_SELECTOR:    O_PRDATA <= {29'h00000000, selector_ff};
          `ADDR_LIMIT:       O_PRDATA <= {25'h0000000, limit_ff};
          `ADDR_WAIT:        O_PRDATA <= {19'h00000, wait_ff};
          `ADDR_SUCCESS:     O_PRDATA <= {16'h0000, success_ff}; // RL10
          `ADDR_COAST:       O_PRDATA <= {18'h00000, coast_ff};
          `ADDR_CTRL:        O_PRDATA <= 32'h00000000;
          `ADDR_STATUS:      O_PRDATA <= {20'h00000, fails_ff, 1'b0, excess_ff,
                                          O_RETRY_ACTIVE, O_FAULT_OUT, 1'b0, state_ff};
          `ADDR_FIRST_FAULT: O_PRDATA <= {16'h0000, first_fault_ff};
          `ADDR_TERM:        O_PRDATA <= {24'h000000, term_ff};
          default:           O_PSLVERR <= 1'b1;
        endcase
      end
      if (apb_wr) begin
        case (I_PADDR)
          `ADDR_SELECTOR:
            if (I_PWDATA[31:0] <= 32'h00000005)
              selector_ff <= I_PWDATA[2:0];
          `ADDR_LIMIT:
            if (I_PWDATA <= 32'h0000000A ||
                (I_PWDATA >= 32'h00000065 && I_PWDATA <= 32'h0000006E))
              limit_ff <= I_PWDATA[6:0];
          `ADDR_WAIT:
            if (I_PWDATA >= 32'h00000001 && I_PWDATA <= 32'h00001770)
              wait_ff <= I_PWDATA[12:0];
          `ADDR_COAST:       coast_ff <= I_PWDATA[13:0];
          `ADDR_CTRL:        sw_reset_ff <= I_PWDATA[`CTRL_FAULT_RESET];
          `ADDR_TERM:        term_ff <= I_PWDATA[7:0];
          default:           sw_reset_ff <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [verif/fault_retry_checker.sv]
// Port-level assertion checker for the fault retry controller
`timescale 1ns/1ps
`default_nettype none
`include "fault_retry_map.vh"
module fault_retry_checker #(
  parameter TICK_CYCLES = 10
) (
  // Clock, reset and settings bus
  input wire logic        I_REF_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_CE,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  // Drive side
  input wire logic        O_TRIP,
  input wire logic        O_RETRY_EXCESS_FAULT,
  input wire logic        O_FAULT_RESET,
  input wire logic        O_RESTART_START,
  input wire logic        O_KEEP_THERMAL,
  input wire logic        O_RETRY_ACTIVE,
  input wire logic        O_TERM_OUT
);
  reg [7:0] term_ff;
  // Shadow of the terminal function code, taken at the completing edge of a write
  always @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N)
      term_ff <= 8'h00;
    else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == `ADDR_TERM)
      term_ff <= I_PWDATA[7:0];
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  a_setup_gets_ready: assert property (I_CE && I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY) else $error("ready held");
  a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY) else $error("error without ready");
  a_restart_in_retry: assert property (O_RESTART_START |-> O_RETRY_ACTIVE)
    else $error("restart outside retry");
  a_restart_single: assert property (O_RESTART_START |=> !O_RESTART_START)
    else $error("restart pulse too long");
  a_reset_keeps_thermal: assert property (O_FAULT_RESET |-> O_KEEP_THERMAL && O_RESTART_START)
    else $error("retry reset without thermal keep");
  a_excess_trips: assert property ($rose(O_RETRY_EXCESS_FAULT) |-> O_TRIP)
    else $error("excess fault without trip");
  a_excess_blocks: assert property (O_RETRY_EXCESS_FAULT |-> !O_RESTART_START && !O_FAULT_RESET)
    else $error("retry after excess");
  a_term_positive: assert property (term_ff == `FUNC_RETRY_POS && O_RETRY_ACTIVE
    && $past(O_RETRY_ACTIVE) |-> O_TERM_OUT) else $error("terminal not on");
  a_term_negative: assert property (term_ff == `FUNC_RETRY_NEG && O_RETRY_ACTIVE
    && $past(O_RETRY_ACTIVE) |-> !O_TERM_OUT) else $error("terminal not off");
  c_restart: cover property (O_RESTART_START);
  c_excess: cover property (O_RETRY_EXCESS_FAULT);
  c_bus_error: cover property (O_PSLVERR);
endmodule
bind fault_retry_controller fault_retry_checker #(.TICK_CYCLES(TICK_CYCLES)) checker_inst (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TRIP(O_TRIP),
  .O_RETRY_EXCESS_FAULT(O_RETRY_EXCESS_FAULT), .O_FAULT_RESET(O_FAULT_RESET),
  .O_RESTART_START(O_RESTART_START), .O_KEEP_THERMAL(O_KEEP_THERMAL),
  .O_RETRY_ACTIVE(O_RETRY_ACTIVE), .O_TERM_OUT(O_TERM_OUT));
`default_nettype wire

// [verif/drive_side_model.sv]
// Behavioural fault sources and restart sequencer facing the retry controller
`timescale 1ns/1ps
`default_nettype none
module drive_side_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Bench commands
  input  wire logic [15:0] i_inject,
  input  wire logic        i_clear,
  input  wire logic        i_slow,
  // Controller side
  input  wire logic        i_fault_reset,
  input  wire logic        i_restart_start,
  output var  logic [15:0] o_faults,
  output var  logic        o_restart_done
);
  logic [2:0] wait_ff;
  logic       busy_ff;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_faults <= 16'h0000;
      o_restart_done <= 1'b0;
      wait_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else begin
      // Trips latch until a reset; a new trip in the same cycle still lands
      o_faults <= ((i_fault_reset || i_clear) ? 16'h0000 : o_faults) | i_inject;
      o_restart_done <= 1'b0;
      if (i_restart_start) begin
        busy_ff <= 1'b1;
        wait_ff <= i_slow ? 3'h5 : 3'h0;
      end else if (busy_ff && wait_ff == 3'h0) begin
        busy_ff <= 1'b0;
        o_restart_done <= 1'b1;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/fault_retry_controller_bench.sv]
// Self-checking bench for the fault retry controller
`timescale 1ns/1ps
`default_nettype none
`include "fault_retry_map.vh"
module fault_retry_controller_bench;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic        clk, rst_n, psel, penable, pwrite, ext_rst, clr, slow, er, ce, fly;
  logic        pready, pslverr, trip, fout, excess, frst, rstart, keep, active, term, rdone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] faults, inject;
  int          num_errors, tests_run, cyc, restarts, n, i;
  row_t        rows [13];
  int          sel_t [8] = '{1, 1, 5, 0, 2, 3, 4, 5};
  int          lim_t [8] = '{3, 0, 3, 3, 3, 3, 3, 3};
  int          bit_t [8] = '{6, 0, 1, 11, 4, 5, 13, 2};
  logic        exp_t [8] = '{0, 0, 0, 1, 1, 1, 1, 1};
  fault_retry_controller #(.TICK_CYCLES(10)) fault_retry_controller_inst (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_FAULTS(faults), .I_EXT_FAULT_RESET(ext_rst),
    .I_RESTART_DONE(rdone), .O_TRIP(trip), .O_FAULT_OUT(fout), .O_RETRY_EXCESS_FAULT(excess),
    .O_FAULT_RESET(frst), .O_RESTART_START(rstart), .O_RESTART_FLYING(fly), .O_KEEP_THERMAL(keep),
    .O_RETRY_ACTIVE(active), .O_TERM_OUT(term));
  drive_side_model drive_side_model_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_inject(inject), .i_clear(clr), .i_slow(slow),
    .i_fault_reset(frst), .i_restart_start(rstart), .o_faults(faults), .o_restart_done(rdone));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, g, x);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  // One APB transfer; holds the request until ready is sampled high, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fault(input int b);
    inject <= 16'h0001 << b;
    @(posedge clk);
    inject <= 16'h0000;
    @(posedge clk);
  endtask
  task automatic wait_rs;
    n = 0;
    while (rstart !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk1(rstart, 1'b1);
  endtask
  task automatic expect_restart(input logic x);
    int r0;
    r0 = restarts;
    repeat (60) @(posedge clk);
    chk1(restarts != r0, x);
  endtask
  // Clears the trip sources first, then applies an external fault reset
  task automatic clear_all;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    ext_rst <= 1'b1;
    repeat (4) @(posedge clk);
    ext_rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk1(trip, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (rstart === 1'b1) restarts++;
    if (cyc == 10000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, ext_rst, clr, slow} = 7'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    inject = 16'h0000;
    rows = '{'{1'b0, `ADDR_SELECTOR, 32'h0, 32'h0, 1'b0}, '{1'b0, `ADDR_LIMIT, 32'h0, 32'h0, 1'b0},
      '{1'b0, `ADDR_WAIT, 32'h0, 32'hA, 1'b0}, '{1'b0, `ADDR_COAST, 32'h0, 32'h270F, 1'b0},
      '{1'b0, `ADDR_SUCCESS, 32'h0, 32'h0, 1'b0}, '{1'b0, `ADDR_TERM, 32'h0, 32'h0, 1'b0},
      '{1'b1, `ADDR_WAIT, 32'h0, 32'h0, 1'b0}, '{1'b0, `ADDR_WAIT, 32'h0, 32'hA, 1'b0},
      '{1'b1, `ADDR_WAIT, 32'h1, 32'h0, 1'b0}, '{1'b1, `ADDR_LIMIT, 32'hB, 32'h0, 1'b0},
      '{1'b0, `ADDR_LIMIT, 32'h0, 32'h0, 1'b0}, '{1'b1, `ADDR_SELECTOR, 32'h6, 32'h0, 1'b0},
      '{1'b0, 12'h024, 32'h0, 32'h0, 1'b1}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].x);
      chk1(er, rows[i].e);
    end
    chk1(fly, 1'b0);
    apb(1'b1, `ADDR_LIMIT, 32'h3);
    apb(1'b1, `ADDR_SELECTOR, 32'h1);
    apb(1'b1, `ADDR_TERM, 32'h40);
    apb(1'b1, `ADDR_COAST, 32'h5);
    slow <= 1'b1;
    fault(0);
    fault(2);
    wait_rs();
    chk1(active, 1'b1);
    chk1(fout, 1'b0);
    chk1(term, 1'b1);
    chk1(fly, 1'b1);
    apb(1'b0, `ADDR_FIRST_FAULT, 32'h0);
    chk(rd, 32'h1);
    repeat (70) @(posedge clk);
    apb(1'b0, `ADDR_SUCCESS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `ADDR_SUCCESS, 32'h0);
    apb(1'b0, `ADDR_SUCCESS, 32'h0);
    chk(rd, 32'h0);
    slow <= 1'b0;
    for (i = 0; i < 8; i++) begin
      apb(1'b1, `ADDR_SELECTOR, sel_t[i]);
      apb(1'b1, `ADDR_LIMIT, lim_t[i]);
      fault(bit_t[i]);
      expect_restart(exp_t[i]);
      if (!exp_t[i]) chk1(trip, 1'b1);
      if (!exp_t[i]) clear_all();
      else repeat (60) @(posedge clk);
    end
    apb(1'b1, `ADDR_LIMIT, 32'h66);
    apb(1'b1, `ADDR_SELECTOR, 32'h1);
    apb(1'b1, `ADDR_TERM, 32'hA4);
    for (i = 0; i < 3; i++) begin
      fault(0);
      if (i < 2) wait_rs();
      if (i < 2) chk1(fout, 1'b1);
      if (i < 2) chk1(term, 1'b0);
      repeat (5) @(posedge clk);
    end
    repeat (10) @(posedge clk);
    chk1(excess, 1'b1);
    chk1(trip, 1'b1);
    expect_restart(1'b0);
    clear_all();
    chk1(excess, 1'b0);
    ce <= 1'b0;
    fault(0);
    repeat (20) @(posedge clk);
    chk1(trip, 1'b0);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk1(trip, 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk1(active, 1'b0);
    chk1(fout, 1'b0);
    rst_n <= 1'b1;
    apb(1'b0, `ADDR_SUCCESS, 32'h0);
    chk(rd, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
